// ### bench/flash_array_model.sv
`timescale 1ns/10ps
`default_nettype none
module flash_array_model
  import flash_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic [WADDR_W-1:0] wordAddr,
  input wire logic [31:0] wordData,
  input wire logic progPulse,
  input wire logic erase,
  input wire logic [PAGE_W-1:0] erasePage,
  input wire logic infoSel,
  input wire logic chipErase,
  output logic [7:0] lockByte
);
  logic [31:0] mem [logic [WADDR_W-1:0]];
  logic [31:0] info0 = 32'hFFFFFFFF;
  int eraseCount = 0;
  int progCount = 0;
  time eraseT = 0;
  time progT = 0;
  // lock byte is word 0 of the information page, never a register
  assign lockByte = info0[7:0];
  // array: programming only clears bits, erase brings a page back to ones
  always @(posedge clk) begin
    if (chipErase) begin
      info0 = 32'hFFFFFFFF;
      mem.delete();
    end
    if (erase) begin
      eraseCount++;
      eraseT = $time;
      for (int i = 0; i < 512; i++) begin
        mem.delete({erasePage, i[8:0]});
      end
    end
    if (progPulse) begin
      progCount++;
      progT = $time;
      if (infoSel) begin
        if (wordAddr == '0) info0 = info0 & wordData;
      end else begin
        mem[wordAddr] = peek(wordAddr) & wordData;
      end
    end
  end
  // unwritten words read as erased
  function automatic logic [31:0] peek(input logic [WADDR_W-1:0] a);
    return mem.exists(a) ? mem[a] : 32'hFFFFFFFF;
  endfunction
endmodule
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import flash_ctrl_pkg::*;
  logic clk, rstn, avRead, avWrite, infoPageSel, chipEraseDone, fetchFromFlash;
  logic [AV_ADDR_W-1:0] avAddress;
  logic [31:0] avWriteData, avReadData, flashWordData, rdN, rv;
  logic [3:0] avByteEnable;
  logic avWaitRequest, flashProgram, flashErase, flashInfoSel, dmaReq, fetchStall;
  logic debugEnable, wqN;
  logic [7:0] lockByte;
  logic [WADDR_W-1:0] flashWordAddr;
  logic [PAGE_W-1:0] flashErasePage;
  int err_count = 0;
  int n_compared = 0;
  int dmaN = 0;
  int stallN = 0;
  localparam int ERASE_SHORT = 10;

  embedded_flash_program_erase_ctrl #(.PROG_LEN(6), .ERASE_LEN(ERASE_SHORT))
    u_embedded_flash_program_erase_ctrl (.clk(clk), .rstn(rstn),
    .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
    .avWriteData(avWriteData), .avByteEnable(avByteEnable), .avReadData(avReadData),
    .avWaitRequest(avWaitRequest), .lockByte(lockByte), .infoPageSel(infoPageSel),
    .chipEraseDone(chipEraseDone), .fetchFromFlash(fetchFromFlash),
    .flashWordAddr(flashWordAddr), .flashWordData(flashWordData),
    .flashProgram(flashProgram), .flashErase(flashErase),
    .flashErasePage(flashErasePage), .flashInfoSel(flashInfoSel), .dmaReq(dmaReq),
    .fetchStall(fetchStall), .debugEnable(debugEnable));
  flash_array_model u_flash_array_model (.clk(clk), .wordAddr(flashWordAddr),
    .wordData(flashWordData), .progPulse(flashProgram), .erase(flashErase),
    .erasePage(flashErasePage), .infoSel(flashInfoSel), .chipErase(chipEraseDone),
    .lockByte(lockByte));

  // clock, 4 ns period
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // settled bus answer, sampled at the falling edge, used at the following rising edge
  always @(negedge clk) begin
    wqN <= avWaitRequest;
    rdN <= avReadData;
  end
  // dma request pulse counter
  always @(posedge clk) begin
    if (dmaReq === 1'h1) dmaN <= dmaN + 1;
  end
  // fetch stall cycle counter, measures the erase span
  always @(posedge clk) begin
    if (fetchStall === 1'h1) stallN <= stallN + 1;
  end
  // hang guard
  initial begin
    #400000;
    err_count++;
    give_verdict;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                     input logic [3:0] be = 4'hF);
    int n;
    n = 0;
    avAddress <= {idx, 2'h0};
    avWrite <= wr;
    avRead <= !wr;
    avWriteData <= {24'h000000, d};
    avByteEnable <= be;
    do begin
      @(posedge clk);
      n++;
    end while (wqN !== 1'h0 && n < 2000);
    if (n >= 2000) err_count++;
    rv = rdN;
    avWrite <= 1'h0;
    avRead <= 1'h0;
    @(posedge clk);
  endtask

  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      bus(1'h0, IDX_CTRL, 8'h00);
      n++;
    end while (rv[b] !== 1'h0 && n < 500);
    chk("poll", 32'h0, {31'h0, rv[b]});
  endtask

  task automatic prog4(input logic [31:0] w);
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, IDX_DATA, w[8*i+:8]);
    end
    bus(1'h0, IDX_CTRL, 8'h00);
    chk("word busy", 32'h1, {31'h0, rv[CTRL_WBSY_BIT]});
    poll(CTRL_WBSY_BIT);
  endtask

  task automatic erasePg(input int p, input int exp);
    int e0;
    e0 = u_flash_array_model.eraseCount;
    bus(1'h1, IDX_ADDRH, {1'h0, p[5:0], 1'h0});
    bus(1'h1, IDX_CTRL, 8'h01);
    poll(CTRL_BUSY_BIT);
    chk("erase count", 32'(exp), 32'(u_flash_array_model.eraseCount - e0));
  endtask

  task automatic setLock(input logic [7:0] lk, input logic [7:0] exp, input logic ce);
    if (ce) begin
      chipEraseDone <= 1'h1;
      @(posedge clk);
      chipEraseDone <= 1'h0;
    end
    infoPageSel <= 1'h1;
    bus(1'h1, IDX_ADDRH, 8'h00);
    bus(1'h1, IDX_ADDRL, 8'h00);
    bus(1'h1, IDX_CTRL, 8'h02);
    prog4({24'hFFFFFF, lk});
    bus(1'h1, IDX_CTRL, 8'h00);
    infoPageSel <= 1'h0;
    chk("lock byte", {24'h0, exp}, {24'h0, lockByte});
  endtask

  task automatic t_regs;
    bus(1'h0, IDX_TIMING, 8'h00);
    chk("timing reset", 32'h2A, rv);
    bus(1'h0, IDX_CTRL, 8'h00);
    chk("ctrl reset", 32'h0, rv);
    bus(1'h0, 8'h10, 8'h00);
    chk("unmapped", 32'h0, rv);
    chk("debug on", 32'h1, {31'h0, debugEnable});
    bus(1'h1, IDX_TIMING, {2'h0, TIMING_16MHZ});
    bus(1'h0, IDX_TIMING, 8'h00);
    chk("timing 16", 32'h15, rv);
    bus(1'h1, IDX_TIMING, 8'h07, 4'hE);
    bus(1'h0, IDX_TIMING, 8'h00);
    chk("lane ignored", 32'h15, rv);
    bus(1'h1, IDX_TIMING, 8'h01);
  endtask

  task automatic t_prog;
    int d0;
    d0 = dmaN;
    bus(1'h1, IDX_ADDRH, 8'h02);
    bus(1'h1, IDX_ADDRL, 8'h05);
    bus(1'h1, IDX_CTRL, 8'h02);
    bus(1'h0, IDX_CTRL, 8'h00);
    chk("busy prog", 32'h1, {31'h0, rv[CTRL_BUSY_BIT]});
    prog4(32'h78563412);
    prog4(32'hF0DEBC9A);
    bus(1'h1, IDX_CTRL, 8'h00);
    chk("word a", 32'h78563412, u_flash_array_model.peek(15'h0205));
    chk("word b", 32'hF0DEBC9A, u_flash_array_model.peek(15'h0206));
    chk("dma pulses", 32'h3, 32'(dmaN - d0));
  endtask

  task automatic t_erase;
    int s0;
    s0 = stallN;
    fetchFromFlash <= 1'h1;
    bus(1'h1, IDX_ADDRH, 8'h02);
    bus(1'h1, IDX_CTRL, 8'h01);
    bus(1'h0, IDX_CTRL, 8'h00);
    chk("busy erase", 32'h1, {31'h0, rv[CTRL_BUSY_BIT]});
    chk("stall on", 32'h1, {31'h0, fetchStall});
    poll(CTRL_BUSY_BIT);
    chk("stall off", 32'h0, {31'h0, fetchStall});
    chk("stall span", 32'(ERASE_SHORT + 1), 32'(stallN - s0));
    fetchFromFlash <= 1'h0;
    chk("erased", 32'hFFFFFFFF, u_flash_array_model.peek(15'h0205));
  endtask

  task automatic t_both;
    bus(1'h1, IDX_ADDRL, 8'h00);
    bus(1'h1, IDX_CTRL, 8'h03);
    prog4(32'h44332211);
    bus(1'h1, IDX_CTRL, 8'h00);
    chk("order", 32'h1, 32'(u_flash_array_model.eraseT < u_flash_array_model.progT));
    chk("word c", 32'h44332211, u_flash_array_model.peek(15'h0200));
  endtask

  task automatic t_lock;
    int st[8] = '{0, 32, 48, 56, 60, 62, 63, 64};
    int p0;
    for (int c = 0; c < 8; c++) begin
      setLock({4'h1, c[2:0], 1'h1}, {4'h1, c[2:0], 1'h1}, 1'h1);
      erasePg(st[c] > 63 ? 63 : st[c], st[c] > 63 ? 1 : 0);
      erasePg(st[c] == 0 ? 0 : st[c] - 1, st[c] == 0 ? 0 : 1);
    end
    setLock(8'h0E, 8'h0E, 1'h1);
    erasePg(0, 0);
    erasePg(1, 1);
    chk("debug off", 32'h0, {31'h0, debugEnable});
    setLock(8'h00, 8'h0E, 1'h0);
    p0 = u_flash_array_model.progCount;
    bus(1'h1, IDX_ADDRL, 8'h08);
    bus(1'h1, IDX_CTRL, 8'h02);
    prog4(32'h00000000);
    bus(1'h1, IDX_CTRL, 8'h00);
    chk("guarded prog", 32'h0, 32'(u_flash_array_model.progCount - p0));
  endtask

  task automatic give_verdict;
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial begin
    rstn = 1'h0;
    avAddress = '0;
    avRead = 1'h0;
    avWrite = 1'h0;
    avWriteData = '0;
    avByteEnable = 4'hF;
    infoPageSel = 1'h0;
    chipEraseDone = 1'h0;
    fetchFromFlash = 1'h0;
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    t_regs;
    t_prog;
    t_erase;
    t_both;
    t_lock;
    give_verdict;
  end
endmodule
`default_nettype wire

// ### common/flash_ctrl_pkg.sv
// How it works
// - every fourth byte into the byte port commits one word to the array
// - word busy shows during each word program; software waits before more bytes
// - erase start erases the page chosen by high address bits 6:1
// - erase and program started together: erase finishes before programming
// - general busy stays set through the whole erase, clears on completion
// - page erase lasts about 20 ms
// - start issued from flash fetch stalls instruction fetch until the operation ends
// - lock word writable once per chip erase, through debug port only; the code takes it from any bus master through the byte port
// - three-bit lock size guards the upper pages, 000 all to 111 none
// - boot guard bit zero protects page 0; one leaves it writable
// - debug disable bit zero blocks debug commands, one allows them
// - lock byte comes from information page word 0; bits 7:5 reserved
// - lock word is programmed through the byte port with information page selected
// - timing generator derives all operation timing from the six-bit timing scale
// - timing scale resets to 0x2A (32 MHz); 16 MHz wants 0x15
// - control: busy bit 7, word busy bit 6, program bit 1, erase bit 0
// - program starts at the addressed word; first byte is the least significant
// - flash DMA request pulses each time a word has been stored; the code also pulses it when program mode is entered
package flash_ctrl_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_ADDRL = 8'hAC;
  localparam logic [7:0] IDX_ADDRH = 8'hAD;
  localparam logic [7:0] IDX_CTRL = 8'hAE;
  localparam logic [7:0] IDX_DATA = 8'hAF;
  localparam logic [7:0] IDX_TIMING = 8'hAB;
  localparam logic [7:0] IDX_LOCK = 8'hB0;
  localparam int AV_ADDR_W = 10;
  // control register fields
  localparam int CTRL_BUSY_BIT = 7;
  localparam int CTRL_WBSY_BIT = 6;
  localparam int CTRL_PROG_BIT = 1;
  localparam int CTRL_ERASE_BIT = 0;
  localparam logic [7:0] CTRL_RW_MASK = 8'h3C;
  // timing scale
  localparam logic [5:0] TIMING_RESET = 6'h2A;
  localparam logic [5:0] TIMING_16MHZ = 6'h15;
  // lock byte fields
  localparam int LOCK_DBG_BIT = 0;
  localparam int LOCK_SIZE_LSB = 1;
  localparam int LOCK_BOOT_BIT = 4;
  localparam logic [2:0] PROTECTED_AREA_SIZE_ALL = 3'h0;
  localparam logic [2:0] PROTECTED_AREA_SIZE_NONE = 3'h7;
  localparam logic [6:0] PAGE_COUNT = 7'h40;
  localparam int PAGE_W = 6;
  localparam int WADDR_W = 15;
  localparam logic [1:0] LAST_BYTE = 2'h3;
  // operation times and derived tick counts
  localparam int CLK_PERIOD_NS = 4;
  localparam int PROG_TIME_NS = 20000;
  localparam int ERASE_TIME_NS = 20000000;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NOM_SCALE = 42;
  localparam int PROG_TICKS = (PROG_CYCLES + NOM_SCALE - 1) / NOM_SCALE;
  localparam int ERASE_TICKS = (ERASE_CYCLES + NOM_SCALE - 1) / NOM_SCALE;
  localparam int TICK_W = 18;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASE = 2'b01,
    ST_COLLECT = 2'b10,
    ST_PROG = 2'b11
  } state_t;
endpackage

// ### rtl/embedded_flash_program_erase_ctrl.sv
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module embedded_flash_program_erase_ctrl
  import flash_ctrl_pkg::*;
#(
  parameter int PROG_LEN = PROG_TICKS,
  parameter int ERASE_LEN = ERASE_TICKS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [AV_ADDR_W-1:0] avAddress,
  input wire logic avRead,
  input wire logic avWrite,
  input wire logic [31:0] avWriteData,
  input wire logic [3:0] avByteEnable,
  output logic [31:0] avReadData,
  output logic avWaitRequest,
  input wire logic [7:0] lockByte,
  input wire logic infoPageSel,
  input wire logic chipEraseDone,
  input wire logic fetchFromFlash,
  output logic [WADDR_W-1:0] flashWordAddr,
  output logic [31:0] flashWordData,
  output logic flashProgram,
  output logic flashErase,
  output logic [PAGE_W-1:0] flashErasePage,
  output logic flashInfoSel,
  output logic dmaReq,
  output logic fetchStall,
  output logic debugEnable
);
  state_t state_r, state_nxt;
  logic [7:0] idx, wd;
  logic hit, wrStrobe, wrCtrl, wrData, dataStall, rdDone_r;
  logic [7:0] addrHigh_r, addrLow_r, dataByte_r, ctrlRw_r;
  logic [5:0] timing_r;
  logic [31:0] wordBuf_r;
  logic [1:0] byteCnt_r;
  logic pendingProg_r, lockProgrammed_r, stallSrc_r, infoSel_r;
  logic busyFlag, wordBusy, eraseProt, progProt, progGuard;
  logic timerStart, timerDone, timerRunning;
  logic [TICK_W-1:0] timerLen;
  logic [WADDR_W-1:0] wordAddr;

  // bus decode, byte lane 0 carries register data
  assign idx = avAddress[AV_ADDR_W-1:2];
  assign hit = (avAddress[1:0] == 2'h0);
  assign wd = avWriteData[7:0];
  assign wrStrobe = avWrite && !avWaitRequest && avByteEnable[0] && hit;
  assign wrCtrl = wrStrobe && (idx == IDX_CTRL);
  assign wrData = wrStrobe && (idx == IDX_DATA);

  // byte writes wait while a word or page operation is running
  assign dataStall = avWrite && hit && (idx == IDX_DATA)
                     && (state_r == ST_ERASE || state_r == ST_PROG);
  assign avWaitRequest = (avRead && !rdDone_r) || dataStall;

  // status flags
  assign busyFlag = (state_r != ST_IDLE);
  assign wordBusy = (state_r == ST_PROG);
  assign wordAddr = {addrHigh_r[6:0], addrLow_r};
  assign flashWordAddr = wordAddr;
  assign flashErasePage = addrHigh_r[6:1];
  assign flashWordData = wordBuf_r;

  // protection decode for the erase page and the program page
  flash_page_guard eraseGuard (
    .lockByte(lockByte),
    .page(addrHigh_r[6:1]),
    .isProtected(eraseProt)
  );
  flash_page_guard progGuardDec (
    .lockByte(lockByte),
    .page(wordAddr[WADDR_W-1 -: PAGE_W]),
    .isProtected(progProt)
  );

  // information page: only the lock word, once per chip erase
  assign progGuard = infoSel_r ? (wordAddr != '0 || lockProgrammed_r) : progProt;

  // operation timer
  flash_op_timer #(
    .TW(TICK_W)
  ) opTimer (
    .clk(clk),
    .rstn(rstn),
    .start(timerStart),
    .lenTicks(timerLen),
    .scale(timing_r),
    .done(timerDone),
    .running(timerRunning)
  );

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    timerStart = 1'b0;
    timerLen = TICK_W'(PROG_LEN);
    case (state_r)
      ST_IDLE: begin
        if (wrCtrl) begin
          if (wd[CTRL_ERASE_BIT] && !eraseProt) begin
            state_nxt = ST_ERASE;
            timerStart = 1'b1;
            timerLen = TICK_W'(ERASE_LEN);
          end else if (wd[CTRL_PROG_BIT]) begin
            state_nxt = ST_COLLECT;
          end
        end
      end
      ST_ERASE: begin
        if (timerDone) begin
          state_nxt = pendingProg_r ? ST_COLLECT : ST_IDLE;
        end
      end
      ST_COLLECT: begin
        if (wrCtrl && !wd[CTRL_PROG_BIT]) begin
          state_nxt = ST_IDLE;
        end else if (wrData && byteCnt_r == LAST_BYTE) begin
          state_nxt = ST_PROG;
          timerStart = 1'b1;
        end
      end
      ST_PROG: begin
        if (timerDone) begin
          state_nxt = ST_COLLECT;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // remember a program request queued behind an erase, and where the start came from
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pendingProg_r <= 1'b0;
      stallSrc_r <= 1'b0;
      infoSel_r <= 1'b0;
    end else if (state_r == ST_IDLE && wrCtrl) begin
      pendingProg_r <= wd[CTRL_PROG_BIT];
      stallSrc_r <= fetchFromFlash;
      infoSel_r <= infoPageSel;
    end
  end

  // byte packing, first byte ends up least significant
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wordBuf_r <= 32'h0000_0000;
      byteCnt_r <= 2'h0;
      dataByte_r <= 8'h00;
    end else begin
      if (wrData) begin
        dataByte_r <= wd;
      end
      if (state_r != ST_COLLECT && state_nxt == ST_COLLECT && state_r != ST_PROG) begin
        byteCnt_r <= 2'h0;
      end else if (state_r == ST_COLLECT && wrData) begin
        wordBuf_r <= {wd, wordBuf_r[31:8]};
        byteCnt_r <= byteCnt_r + 2'h1;
      end
    end
  end

  // address registers, advance by one word after each program
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addrHigh_r <= 8'h00;
      addrLow_r <= 8'h00;
    end else if (state_r == ST_PROG && timerDone) begin
      {addrHigh_r[6:0], addrLow_r} <= wordAddr + WADDR_W'(1);
    end else if (wrStrobe && idx == IDX_ADDRH) begin
      addrHigh_r <= wd;
    end else if (wrStrobe && idx == IDX_ADDRL) begin
      addrLow_r <= wd;
    end
  end

  // timing scale and plain control bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timing_r <= TIMING_RESET;
      ctrlRw_r <= 8'h00;
    end else begin
      if (wrStrobe && idx == IDX_TIMING) begin
        timing_r <= wd[5:0];
      end
      if (wrCtrl) begin
        ctrlRw_r <= wd & CTRL_RW_MASK;
      end
    end
  end

  // lock word written-once flag, a new write wins over chip erase
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lockProgrammed_r <= 1'b0;
    end else if (flashProgram && flashInfoSel && wordAddr == '0) begin
      lockProgrammed_r <= 1'b1;
    end else if (chipEraseDone) begin
      lockProgrammed_r <= 1'b0;
    end
  end

  // array strobes, DMA trigger and debug enable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flashErase <= 1'b0;
      flashProgram <= 1'b0;
      flashInfoSel <= 1'b0;
      dmaReq <= 1'b0;
      debugEnable <= 1'b0;
    end else begin
      flashErase <= (state_r == ST_IDLE && state_nxt == ST_ERASE);
      flashProgram <= (state_r == ST_COLLECT && state_nxt == ST_PROG && !progGuard);
      flashInfoSel <= (state_nxt == ST_IDLE) ? 1'b0 : infoSel_r | (state_r == ST_IDLE
                      && infoPageSel);
      dmaReq <= (state_r != ST_COLLECT && state_nxt == ST_COLLECT);
      debugEnable <= lockByte[LOCK_DBG_BIT];
    end
  end

  // fetch stall while an operation started from flash runs
  assign fetchStall = stallSrc_r && (state_r == ST_ERASE || state_r == ST_PROG);

  // read path, one wait cycle then registered data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdDone_r <= 1'b0;
      avReadData <= 32'h0000_0000;
    end else begin
      rdDone_r <= avRead && !rdDone_r;
      if (avRead && !rdDone_r) begin
        avReadData <= 32'h0000_0000;
        if (hit) begin
          case (idx)
            IDX_CTRL: avReadData[7:0] <= ctrlRw_r | {busyFlag, wordBusy, 6'h00};
            IDX_DATA: avReadData[7:0] <= dataByte_r;
            IDX_ADDRH: avReadData[7:0] <= addrHigh_r;
            IDX_ADDRL: avReadData[7:0] <= addrLow_r;
            IDX_TIMING: avReadData[7:0] <= {2'h0, timing_r};
            IDX_LOCK: avReadData[8:0] <= {lockProgrammed_r, 3'h0, lockByte[4:0]};
            default: avReadData <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // checks
  erase_busy_a: assert property (@(posedge clk) disable iff (!rstn)
    flashErase |-> busyFlag && !wordBusy && timerRunning)
    else $error("erase running without busy");
  erase_page_a: assert property (@(posedge clk) disable iff (!rstn)
    flashErase |-> !eraseProt && state_r == ST_ERASE)
    else $error("erase issued on protected page");
  word_commit_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == ST_COLLECT && wrData && byteCnt_r == LAST_BYTE) |=> wordBusy
      && (flashProgram == !$past(progGuard)))
    else $error("fourth byte did not commit a word");
  word_busy_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(wordBusy) |-> wordBusy throughout (##1 !timerDone [*1]))
    else $error("word busy dropped early");
  erase_first_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == ST_ERASE && timerDone && pendingProg_r) |=> state_r == ST_COLLECT && dmaReq)
    else $error("program not started after erase");
  dma_after_word_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == ST_PROG && timerDone) |=> dmaReq && !wordBusy)
    else $error("no dma request after word store");
  timing_reset_a: assert property (@(posedge clk) disable iff (!rstn)
    !$past(rstn) |-> timing_r == TIMING_RESET)
    else $error("timing scale reset value wrong");
  guard_a: assert property (@(posedge clk) disable iff (!rstn)
    flashProgram |-> !$past(progGuard))
    else $error("program issued to protected word");
  fetch_stall_a: assert property (@(posedge clk) disable iff (!rstn)
    fetchStall |-> busyFlag ##1 (fetchStall || !busyFlag || wordBusy || state_r == ST_COLLECT))
    else $error("fetch stall outside an operation");
  stall_byte_a: assert property (@(posedge clk) disable iff (!rstn)
    (avWrite && hit && idx == IDX_DATA && (wordBusy || state_r == ST_ERASE))
      |-> avWaitRequest)
    else $error("byte accepted during an operation");
  dma_single_a: assert property (@(posedge clk) disable iff (!rstn)
    dmaReq |=> !dmaReq)
    else $error("dma request longer than one cycle");
  erase_start_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == ST_IDLE && wrCtrl && wd[CTRL_ERASE_BIT] && !eraseProt) |=> flashErase
      && flashErasePage == $past(addrHigh_r[6:1]))
    else $error("erase start not issued");
  lock_once_a: assert property (@(posedge clk) disable iff (!rstn)
    (flashProgram && flashInfoSel) |-> !$past(lockProgrammed_r) && wordAddr == '0)
    else $error("lock word programmed twice");
  timing_load_a: assert property (@(posedge clk) disable iff (!rstn)
    (wrStrobe && idx == IDX_TIMING) |=> timing_r == $past(wd[5:0]))
    else $error("timing scale write lost");
  byte_count_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == ST_COLLECT && wrData) |=> byteCnt_r == $past(byteCnt_r) + 2'h1)
    else $error("byte count did not advance");
endmodule
`default_nettype wire

// ### rtl/flash_op_timer.sv
`timescale 1ns/10ps
`default_nettype none
module flash_op_timer
  import flash_ctrl_pkg::*;
#(
  parameter int TW = TICK_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [TW-1:0] lenTicks,
  input wire logic [5:0] scale,
  output logic done,
  output logic running
);
  logic [5:0] pre_r;
  logic [TW-1:0] ticks_r;
  logic tick;

  // prescaler: one tick every scale cycles, zero treated as one
  assign tick = (pre_r + 6'h01 >= scale);

  // tick countdown
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_r <= 6'h00;
      ticks_r <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        pre_r <= 6'h00;
        ticks_r <= lenTicks;
        running <= 1'b1;
      end else if (running) begin
        pre_r <= tick ? 6'h00 : pre_r + 6'h01;
        if (tick) begin
          if (ticks_r <= TW'(1)) begin
            running <= 1'b0;
            done <= 1'b1;
          end else begin
            ticks_r <= ticks_r - TW'(1);
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/flash_page_guard.sv
`timescale 1ns/10ps
`default_nettype none
module flash_page_guard
  import flash_ctrl_pkg::*;
(
  input wire logic [7:0] lockByte,
  input wire logic [PAGE_W-1:0] page,
  output logic isProtected
);
  logic [2:0] size;
  logic [6:0] limit;

  // upper-area and boot page decode
  always_comb begin
    size = lockByte[LOCK_SIZE_LSB +: 3];
    limit = PAGE_COUNT - (PAGE_COUNT >> size);
    case (size)
      PROTECTED_AREA_SIZE_ALL: isProtected = 1'b1;
      PROTECTED_AREA_SIZE_NONE: isProtected = 1'b0;
      default: isProtected = ({1'b0, page} >= limit);
    endcase
    if (page == '0 && !lockByte[LOCK_BOOT_BIT]) begin
      isProtected = 1'b1;
    end
  end
endmodule
`default_nettype wire
